//--- sim/psc_ctrl_chk.sv
// port assertions of the alignment controller
// assumes one clock domain and a bind onto psc_ctrl
`default_nettype none
module psc_ctrl_chk (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic spi_sclk_o,
  input wire logic spi_mosi_o,
  input wire logic spi_cs_n_o,
  input wire logic align_pulse_o,
  input wire logic ref_stop_o
);
  // ****************************************
  // width and frame bit counters
  // ****************************************
  logic [7:0] hi_reg, stop_reg, rise_reg;
  logic sclk_q_reg;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      hi_reg <= 8'h00;
      stop_reg <= 8'h00;
      rise_reg <= 8'h00;
      sclk_q_reg <= 1'b0;
    end else begin
      hi_reg <= align_pulse_o ? hi_reg + 8'h01 : 8'h00;
      stop_reg <= ref_stop_o ? stop_reg + 8'h01 : 8'h00;
      sclk_q_reg <= spi_sclk_o;
      rise_reg <= spi_cs_n_o ? 8'h00 :
        rise_reg + {7'h00, spi_sclk_o & ~sclk_q_reg};
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  pulse_width_a: assert property ($fell(align_pulse_o) |->
    hi_reg == psc_pkg::ALIGN_PULSE_CYC) else $error("align pulse width");
  pulse_cause_a: assert property ($rose(align_pulse_o) |->
    $past(wr_i) && $past(addr_i) == psc_pkg::A_CTRL && $past(wdata_i[1]))
    else $error("align pulse without go");
  stop_width_a: assert property ($fell(ref_stop_o) |->
    stop_reg == psc_pkg::REF_STOP_CYC) else $error("ref stop width");
  stop_quiet_a: assert property (ref_stop_o |->
    spi_cs_n_o && !align_pulse_o) else $error("traffic during ref stop");
  pin_quiet_a: assert property (align_pulse_o |-> spi_cs_n_o)
    else $error("frame during align pulse");
  frame_bits_a: assert property ($rose(spi_cs_n_o) |->
    rise_reg == 8'h18) else $error("frame not 24 bits");
  frame_gap_a: assert property ($rose(spi_cs_n_o) |=> spi_cs_n_o)
    else $error("frame gap too short");
  write_bit_a: assert property ($fell(spi_cs_n_o) |-> !spi_mosi_o)
    else $error("frame not a write");
  mosi_hold_a: assert property (spi_sclk_o && $past(spi_sclk_o) |->
    $stable(spi_mosi_o)) else $error("data moved while clock high");
  read_idle_a: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0000_0000)
    else $error("read data outside answer");
  cover property ($fell(align_pulse_o));
  cover property ($fell(ref_stop_o));
  cover property ($rose(spi_cs_n_o));
endmodule
bind psc_ctrl psc_ctrl_chk i_psc_ctrl_chk (.clk_sys_i(clk_sys_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .spi_sclk_o(spi_sclk_o),
  .spi_mosi_o(spi_mosi_o), .spi_cs_n_o(spi_cs_n_o),
  .align_pulse_o(align_pulse_o), .ref_stop_o(ref_stop_o));
`default_nettype wire

//--- sim/psc_ctrl_tb.sv
// self-checking bench of the alignment controller
// assumes the device model logs every frame it receives
`default_nettype none
module psc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i, reset_i, wr_i, rd_i;
  logic spi_sclk_o, spi_mosi_o, spi_cs_n_o, align_pulse_o, ref_stop_o;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rv, seed;
  int errors, samples_checked, hi_n, stop_n;
  psc_ctrl #(.SPI_DIV(2)) i_psc_ctrl (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .spi_sclk_o(spi_sclk_o),
    .spi_mosi_o(spi_mosi_o), .spi_cs_n_o(spi_cs_n_o),
    .align_pulse_o(align_pulse_o), .ref_stop_o(ref_stop_o));
  psc_dev_model i_psc_dev (.spi_sclk_i(spi_sclk_o), .spi_mosi_i(spi_mosi_o),
    .spi_cs_n_i(spi_cs_n_o), .align_pulse_i(align_pulse_o),
    .ref_stop_i(ref_stop_o));
  // ****************************************
  // clock, counters, helpers
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    if (align_pulse_o === 1'b1) hi_n++;
    if (ref_stop_o === 1'b1) stop_n++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] fr(input logic [15:0] a,
    input logic [7:0] d);
    return {1'b0, a[14:0], d};
  endfunction
  function automatic logic [23:0] nxt();
    if (i_psc_dev.log_q.size() == 0) return 24'hxx_xxxx;
    return i_psc_dev.log_q.pop_front();
  endfunction
  // {fall, duty, delay}; group a dividers get their own delays in bands 2 to 5
  function automatic logic [5:0] tval(input int b, input logic [5:0] r);
    bit ga;
    int d;
    ga = r inside {3, 6, 12, 14, 15, 24, [26:31], 46, [48:63]};
    case (b)
      0: d = 3;
      1: d = 4;
      2: d = ga ? 1 : 0;
      3: d = ga ? 3 : 1;
      4: d = ga ? 4 : 1;
      default: d = ga ? 0 : 1;
    endcase
    return {b > 1, b < 2 ? 2'h0 : (b > 4 ? 2'h2 : 2'h3), 3'(d)};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    rv = 32'h0000_0000;
    while (rv[1] !== 1'b1 && n < 3000) begin
      rd(psc_pkg::A_STATUS);
      n++;
    end
    if (rv[1] !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic cfg(input int i);
    logic [2:0] m;
    logic [5:0] r, t;
    logic [1:0] o;
    logic [7:0] dl;
    int n;
    m = (i % 3 == 0) ? 3'h0 : ((i % 3 == 1) ? 3'h4 : 3'h5);
    n = (m == 3'h0 ? 10 : (m == 3'h4 ? 23 : 27)) + i / 3;
    o = 2'(i);
    seed = lfsr(seed);
    r = (i < 6) ? seed[5:0] : ((i < 12) ? {2'b11, seed[3:0]} : 6'h04);
    if (r == 6'h00) r = 6'h01;
    t = tval(i % 6, r);
    dl = {5'h00, t[2:0]};
    wr(psc_pkg::A_SETUP, {4'h0, seed[11:8], 2'b00, seed[13:12], 1'b0, m,
      5'h00, 3'(i % 6), 2'b00, r});
    wr(psc_pkg::A_NDIV, {11'h000, seed[20:16], 4'h0, 12'(n)});
    wr(psc_pkg::A_WAIT, {16'h0000, seed[31:16]});
    wr(psc_pkg::A_CTRL, {28'h000_0000, o, 2'b01});
    wr(psc_pkg::A_CTRL, {28'h000_0000, ~o, 2'b00});
    wait_done();
    rd(psc_pkg::A_CTRL);
    check("ctrl", rv, {28'h000_0000, o, 2'b00});
    check("frames", i_psc_dev.log_q.size(), 12);
    check("resync", nxt(), fr(16'h001E, {3'h7, seed[20:16]}));
    check("sel", nxt(), fr(16'h0053, {2'b00, o[0], 5'h00}));
    check("rdiv", nxt(), fr(16'h0020, {2'b00, r}));
    check("drclk", nxt(), fr(16'h002D, 8'h40));
    check("dly0", nxt(), fr(16'h0033, dl));
    check("dly1", nxt(), fr(16'h0034, dl));
    check("dly2", nxt(), fr(16'h0035, dl));
    check("edge", nxt(), fr(16'h0036, {5'h00, t[5:3]}));
    check("dith", nxt(), fr(16'h0037, {2'b00, seed[13:8]}));
    check("wlo", nxt(), fr(16'h0038, seed[23:16]));
    check("whi", nxt(), fr(16'h0039, seed[31:24]));
    check("mode", nxt(), fr(16'h0032, {2'b00, o[1], 2'b00, m}));
    $display("config test %0d done", i);
  endtask
  task automatic refuse(input logic [2:0] m, input logic [11:0] n);
    wr(psc_pkg::A_SETUP, {13'h0000, m, 16'h0004});
    wr(psc_pkg::A_NDIV, {20'h0_0000, n});
    wr(psc_pkg::A_CTRL, 32'h0000_0001);
    rd(psc_pkg::A_STATUS);
    check("nerr", rv[2:0], 3'h4);
    check("quiet", spi_cs_n_o, 1'b1);
    $display("refusal test done");
  endtask
  task automatic align(input logic sw);
    int a0;
    a0 = i_psc_dev.aligns;
    hi_n = 0;
    stop_n = 0;
    wr(psc_pkg::A_CTRL, {28'h000_0000, 1'b0, sw, 2'b10});
    wait_done();
    check("pulse", hi_n, sw ? 0 : psc_pkg::ALIGN_PULSE_CYC);
    check("stop", stop_n, sw ? psc_pkg::REF_STOP_CYC : 0);
    check("aligned", i_psc_dev.aligns, a0 + 1);
    if (sw) begin
      check("swset", nxt(), fr(psc_pkg::DEV_SWSYNC, 8'h80));
      check("swclr", nxt(), fr(psc_pkg::DEV_SWSYNC, 8'h00));
    end
    $display("align test done");
  endtask
  initial begin
    errors = 0;
    samples_checked = 0;
    seed = 32'h7709_c409;
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0000_0000;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(psc_pkg::A_STATUS);
    check("status", rv, 32'h0000_0000);
    check("idle", {spi_cs_n_o, spi_sclk_o, align_pulse_o, ref_stop_o},
      4'h8);
    for (int i = 0; i < 18; i++) cfg(i);
    align(1'b1);
    cfg(12);
    align(1'b0);
    refuse(3'h0, 12'h009);
    refuse(3'h4, 12'h016);
    refuse(3'h5, 12'h01A);
    refuse(3'h1, 12'h040);
    wr(4'hA, 32'hFFFF_FFFF);
    rd(psc_pkg::A_CTRL);
    check("unmapped", rv, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- sim/psc_dev_model.sv
// behavioural synthesizer: serial write port, align pin, ref stop
// assumes 24-bit write frames, msb first, taken on rising serial clock
`default_nettype none
module psc_dev_model (
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_cs_n_i,
  input wire logic align_pulse_i,
  input wire logic ref_stop_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // register file and align logic
  // ****************************************
  logic [23:0] sh = 24'h00_0000;
  logic [23:0] log_q[$];
  logic [7:0] regs[int];
  logic held_reset = 1'b0;
  int nbits = 0;
  int aligns = 0;
  function automatic bit sw_sel();
    return regs.exists(32'h53) && regs[32'h53][5] === 1'b1;
  endfunction
  always @(negedge spi_cs_n_i) nbits = 0;
  always @(posedge spi_sclk_i) begin
    if (!spi_cs_n_i) begin
      sh = {sh[22:0], spi_mosi_i};
      nbits++;
    end
  end
  // short frames logged as unknown so the bench sees them
  always @(posedge spi_cs_n_i) begin
    if (nbits == 24) begin
      log_q.push_back(sh);
      regs[int'(sh[22:8])] = sh[7:0];
    end else if (nbits != 0) begin
      log_q.push_back(24'hxx_xxxx);
    end
  end
  always @(posedge align_pulse_i) begin
    if (!sw_sel()) held_reset = 1'b1;
  end
  always @(negedge align_pulse_i) begin
    if (held_reset) aligns++;
    held_reset = 1'b0;
  end
  always @(negedge ref_stop_i) begin
    if (sw_sel() && regs.exists(32'h1F) && regs[32'h1F][7]) aligns++;
  end
endmodule
`default_nettype wire

//--- src/psc_ctrl.sv
// host controller: programs alignment and modulator settings of a
// fractional-n synthesizer over its serial port and drives its align pin
// assumes all inputs synchronous to clk_sys_i; write-only device port
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`default_nettype none
module psc_ctrl #(
  parameter int SPI_DIV = 4,
  parameter logic [15:0] DEV_DLY_ALIGN = 16'h0033,
  parameter logic [15:0] DEV_DLY_DOWN = 16'h0034,
  parameter logic [15:0] DEV_DLY_DCLK = 16'h0035,
  parameter logic [15:0] DEV_REFEDGE = 16'h0036,
  parameter logic [15:0] DEV_DITHER = 16'h0037,
  parameter logic [15:0] DEV_WAIT_LO = 16'h0038,
  parameter logic [15:0] DEV_WAIT_HI = 16'h0039
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic spi_sclk_o,
  output logic spi_mosi_o,
  output logic spi_cs_n_o,
  output logic align_pulse_o,
  output logic ref_stop_o
);
  // refused at elaboration: the divider reload needs at least one cycle
  if (SPI_DIV < 1) begin : g_bad_div
    $error("SPI_DIV must be at least 1");
  end

  // ************************************************************
  // software registers
  // ************************************************************
  logic [31:0] setup_reg;
  logic [31:0] ndiv_reg;
  logic [15:0] wait_reg;
  logic sel_sw_reg;
  logic delmode_reg;
  logic busy_reg;
  logic done_reg;
  logic nerr_reg;
  logic go_cfg;
  logic go_align;
  logic nok;
  logic fin;
  psc_pkg::psc_state_t state_reg;
  logic [3:0] step_reg;

  assign go_cfg = wr_i && addr_i == psc_pkg::A_CTRL
    && wdata_i[psc_pkg::C_CFG] && !busy_reg;
  assign go_align = wr_i && addr_i == psc_pkg::A_CTRL
    && wdata_i[psc_pkg::C_ALIGN] && !busy_reg && !go_cfg;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      setup_reg <= 32'h0000_0000;
      ndiv_reg <= 32'h0000_0000;
      wait_reg <= 16'h0000;
      sel_sw_reg <= 1'b0;
      delmode_reg <= 1'b0;
    end else if (wr_i && !busy_reg) begin
      unique case (addr_i)
        psc_pkg::A_CTRL: begin
          sel_sw_reg <= wdata_i[psc_pkg::C_SWSEL];
          delmode_reg <= wdata_i[psc_pkg::C_DELMODE];
        end
        psc_pkg::A_SETUP: setup_reg <= wdata_i;
        psc_pkg::A_NDIV: ndiv_reg <= wdata_i;
        psc_pkg::A_WAIT: wait_reg <= wdata_i[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        psc_pkg::A_CTRL: rdata_o <= {28'h000_0000, delmode_reg,
          sel_sw_reg, 2'b00};
        psc_pkg::A_SETUP: rdata_o <= setup_reg;
        psc_pkg::A_NDIV: rdata_o <= ndiv_reg;
        psc_pkg::A_WAIT: rdata_o <= {16'h0000, wait_reg};
        psc_pkg::A_STATUS: rdata_o <= {20'h0_0000, step_reg,
          2'b00, state_reg, nerr_reg, done_reg, busy_reg};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // setting tables
  // ************************************************************
  function automatic logic rdiv_group_a(input logic [5:0] r);
    unique case (r)
      6'd3, 6'd6, 6'd12, 6'd14, 6'd15, 6'd24, 6'd46: return 1'b1;
      default: return (r >= 6'd26 && r <= 6'd31) || r >= 6'd48;
    endcase
  endfunction

  // band: 0 >=225, 1 200-225, 2 148-200, 3 130-148, 4 85-130, 5 <85
  function automatic psc_pkg::psc_phase_t phase_set(
      input logic [2:0] band, input logic grp_a);
    psc_pkg::psc_phase_t p;
    p = '{fall: 1'b1, duty: 2'h3, dly: 3'h1};
    unique case (band)
      3'd0: p = '{fall: 1'b0, duty: 2'h0, dly: 3'h3};
      3'd1: p = '{fall: 1'b0, duty: 2'h0, dly: 3'h4};
      3'd2: p.dly = grp_a ? 3'h1 : 3'h0;
      3'd3: p.dly = grp_a ? 3'h3 : 3'h1;
      3'd4: p.dly = grp_a ? 3'h4 : 3'h1;
      default: begin
        p.duty = 2'h2;
        p.dly = grp_a ? 3'h0 : 3'h1;
      end
    endcase
    return p;
  endfunction

  logic [5:0] rdiv;
  logic [2:0] band;
  logic [2:0] mode;
  logic [11:0] nint;
  psc_pkg::psc_phase_t ph;
  assign rdiv = setup_reg[5:0];
  assign band = setup_reg[10:8];
  assign mode = setup_reg[18:16];
  assign nint = ndiv_reg[11:0];
  assign ph = phase_set(band, rdiv_group_a(rdiv));

  // unsupported mode codes are refused outright
  always_comb begin
    unique case (mode)
      psc_pkg::MODE_JIT: nok = nint >= psc_pkg::NMIN_JIT;
      psc_pkg::MODE_SPUR: nok = nint >= psc_pkg::NMIN_SPUR;
      psc_pkg::MODE_PN: nok = nint >= psc_pkg::NMIN_PN;
      default: nok = 1'b0;
    endcase
  end

  // ************************************************************
  // device write list
  // ************************************************************
  function automatic psc_pkg::psc_frame_t step_frame(input logic [3:0] s);
    psc_pkg::psc_frame_t f;
    f = '{addr: psc_pkg::DEV_SWSYNC, data: 8'h00};
    unique case (s)
      4'd0: begin
        f.addr = psc_pkg::DEV_RESYNC;
        f.data = {3'b000, ndiv_reg[20:16]};
        f.data[psc_pkg::B_TIMED] = 1'b1;
        f.data[psc_pkg::B_REFRST] = 1'b1;
        f.data[psc_pkg::B_REALIGN] = 1'b1;
      end
      4'd1: begin
        f.addr = psc_pkg::DEV_SYNCSEL;
        f.data[psc_pkg::B_SEL] = sel_sw_reg;
      end
      4'd2: f = '{addr: psc_pkg::DEV_RDIV, data: {2'b00, rdiv}};
      4'd3: begin
        f.addr = psc_pkg::DEV_DRCLK;
        f.data[psc_pkg::B_DRCLK] = 1'b1;
      end
      4'd4: f = '{addr: DEV_DLY_ALIGN, data: {5'h00, ph.dly}};
      4'd5: f = '{addr: DEV_DLY_DOWN, data: {5'h00, ph.dly}};
      4'd6: f = '{addr: DEV_DLY_DCLK, data: {5'h00, ph.dly}};
      4'd7: f = '{addr: DEV_REFEDGE,
        data: {5'h00, ph.fall, ph.duty}};
      4'd8: f = '{addr: DEV_DITHER,
        data: {2'b00, setup_reg[21:20], setup_reg[27:24]}};
      4'd9: f = '{addr: DEV_WAIT_LO, data: wait_reg[7:0]};
      4'd10: f = '{addr: DEV_WAIT_HI, data: wait_reg[15:8]};
      4'd11: begin
        f.addr = psc_pkg::DEV_MODE;
        f.data = {5'h00, mode};
        f.data[psc_pkg::B_DELMODE] = delmode_reg;
      end
      4'd12: f.data[psc_pkg::B_SWSYNC] = 1'b1;
      default: ;
    endcase
    return f;
  endfunction

  // ************************************************************
  // serial write engine, mode 0, msb first, write bit low
  // ************************************************************
  localparam int FRAME_BITS = 24;
  logic [$clog2(SPI_DIV + 1)-1:0] div_reg;
  logic tick;
  logic spi_start;
  logic spi_busy_reg;
  logic [23:0] shift_reg;
  logic [4:0] bit_reg;

  assign tick = div_reg == '0;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      div_reg <= '0;
    end else if (tick) begin
      div_reg <= ($clog2(SPI_DIV + 1))'(SPI_DIV - 1);
    end else begin
      div_reg <= div_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      spi_busy_reg <= 1'b0;
      spi_cs_n_o <= 1'b1;
      spi_sclk_o <= 1'b0;
      spi_mosi_o <= 1'b0;
      shift_reg <= 24'h00_0000;
      bit_reg <= 5'h00;
    end else if (spi_start) begin
      spi_busy_reg <= 1'b1;
      shift_reg <= {step_frame(step_reg)} & 24'h7F_FFFF;
      bit_reg <= 5'h00;
    end else if (spi_busy_reg && tick) begin
      if (spi_cs_n_o) begin
        spi_cs_n_o <= 1'b0;
        spi_mosi_o <= shift_reg[23];
      end else if (!spi_sclk_o) begin
        spi_sclk_o <= 1'b1;
      end else begin
        spi_sclk_o <= 1'b0;
        shift_reg <= {shift_reg[22:0], 1'b0};
        spi_mosi_o <= shift_reg[22];
        bit_reg <= bit_reg + 1'b1;
        if (bit_reg == 5'(FRAME_BITS - 1)) begin
          spi_cs_n_o <= 1'b1;
          spi_busy_reg <= 1'b0;
          spi_mosi_o <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  logic [7:0] tim_reg;
  assign spi_start = state_reg == psc_pkg::S_SEND;
  assign fin = state_reg == psc_pkg::S_WAIT && !spi_busy_reg
    && spi_cs_n_o;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= psc_pkg::S_IDLE;
      step_reg <= 4'h0;
      tim_reg <= 8'h00;
      align_pulse_o <= 1'b0;
      ref_stop_o <= 1'b0;
    end else begin
      unique case (state_reg)
        psc_pkg::S_IDLE: begin
          if (go_cfg && nok) begin
            step_reg <= 4'h0;
            state_reg <= psc_pkg::S_SEND;
          // path chosen by the select bit written with the go itself
          end else if (go_align && wdata_i[psc_pkg::C_SWSEL]) begin
            step_reg <= psc_pkg::STEP_SW_SET;
            state_reg <= psc_pkg::S_SEND;
          end else if (go_align) begin
            // pulse spans several ref periods so the device sees it
            align_pulse_o <= 1'b1;
            tim_reg <= 8'(psc_pkg::ALIGN_PULSE_CYC - 1);
            state_reg <= psc_pkg::S_PULSE;
          end
        end
        psc_pkg::S_SEND: state_reg <= psc_pkg::S_WAIT;
        psc_pkg::S_WAIT: begin
          if (fin) begin
            if (step_reg == 4'(psc_pkg::STEP_CFG_LAST)
                || step_reg == psc_pkg::STEP_SW_CLR) begin
              state_reg <= psc_pkg::S_IDLE;
            end else if (step_reg == psc_pkg::STEP_SW_SET) begin
              // stop and restart the reference without runt pulses
              ref_stop_o <= 1'b1;
              tim_reg <= 8'(psc_pkg::REF_STOP_CYC - 1);
              state_reg <= psc_pkg::S_STOP;
            end else begin
              step_reg <= step_reg + 1'b1;
              state_reg <= psc_pkg::S_SEND;
            end
          end
        end
        psc_pkg::S_PULSE: begin
          if (tim_reg == 8'h00) begin
            align_pulse_o <= 1'b0;
            state_reg <= psc_pkg::S_IDLE;
          end else begin
            tim_reg <= tim_reg - 1'b1;
          end
        end
        psc_pkg::S_STOP: begin
          if (tim_reg == 8'h00) begin
            ref_stop_o <= 1'b0;
            step_reg <= psc_pkg::STEP_SW_CLR;
            state_reg <= psc_pkg::S_SEND;
          end else begin
            tim_reg <= tim_reg - 1'b1;
          end
        end
        default: state_reg <= psc_pkg::S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= state_reg != psc_pkg::S_IDLE || go_cfg || go_align;
    end
  end

  // a new command clears done, and clears error unless it is a refused config; completion sets done
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      done_reg <= 1'b0;
      nerr_reg <= 1'b0;
    end else if (go_cfg || go_align) begin
      done_reg <= 1'b0;
      nerr_reg <= go_cfg && !nok;
    end else if ((fin && (step_reg == 4'(psc_pkg::STEP_CFG_LAST)
        || step_reg == psc_pkg::STEP_SW_CLR))
        || (state_reg == psc_pkg::S_PULSE && tim_reg == 8'h00)) begin
      done_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- src/psc_pkg.sv
// constants and carrier types of the synthesizer alignment controller
// assumes a 250 MHz system clock and a write-only serial device port
`default_nettype none
package psc_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS = 4;
  localparam int ALIGN_PULSE_NS = 100;
  localparam int REF_STOP_NS = 200;
  localparam int ALIGN_PULSE_CYC = (ALIGN_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_STOP_CYC = (REF_STOP_NS + CLK_NS - 1) / CLK_NS;
  // ************************************************************
  // device register map
  // ************************************************************
  localparam logic [15:0] DEV_RESYNC = 16'h001E;
  localparam logic [15:0] DEV_SWSYNC = 16'h001F;
  localparam logic [15:0] DEV_RDIV = 16'h0020;
  localparam logic [15:0] DEV_DRCLK = 16'h002D;
  localparam logic [15:0] DEV_MODE = 16'h0032;
  localparam logic [15:0] DEV_SYNCSEL = 16'h0053;
  localparam int B_TIMED = 5;
  localparam int B_REFRST = 6;
  localparam int B_REALIGN = 7;
  localparam int B_SEL = 5;
  localparam int B_DRCLK = 6;
  localparam int B_DELMODE = 5;
  localparam int B_SWSYNC = 7;
  // ************************************************************
  // own software registers (word index)
  // ************************************************************
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_SETUP = 4'h1;
  localparam logic [3:0] A_NDIV = 4'h2;
  localparam logic [3:0] A_WAIT = 4'h3;
  localparam logic [3:0] A_STATUS = 4'h4;
  localparam int C_CFG = 0;
  localparam int C_ALIGN = 1;
  localparam int C_SWSEL = 2;
  localparam int C_DELMODE = 3;
  localparam logic [2:0] MODE_JIT = 3'h0;
  localparam logic [2:0] MODE_SPUR = 3'h4;
  localparam logic [2:0] MODE_PN = 3'h5;
  localparam logic [11:0] NMIN_JIT = 12'h00A;
  localparam logic [11:0] NMIN_SPUR = 12'h017;
  localparam logic [11:0] NMIN_PN = 12'h01B;
  localparam int STEP_CFG_LAST = 11;
  localparam logic [3:0] STEP_SW_SET = 4'hC;
  localparam logic [3:0] STEP_SW_CLR = 4'hD;
  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } psc_frame_t;
  typedef struct packed {
    logic fall;
    logic [1:0] duty;
    logic [2:0] dly;
  } psc_phase_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEND = 3'b001,
    S_WAIT = 3'b010,
    S_PULSE = 3'b011,
    S_STOP = 3'b100
  } psc_state_t;
endpackage
`default_nettype wire
